// ===== iir_router.sv
// io interrupt router top: apb registers, pending logic, per-core routing
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iir_router (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // interrupt sources
  input wire logic [iir_pkg::NUM_SRC-1:0] src_in,
  // routed lines, index core*4 + line
  output logic [iir_pkg::NUM_CORE*iir_pkg::NUM_LINE-1:0] core_int_ff,
  // summary interrupt
  output logic irq_ff
);
  import iir_pkg::*;

  //==============================================================
  // helpers
  function automatic logic [WORD_W-1:0] word_idx(input logic [31:0] a);
    word_idx = a[WORD_LSB +: WORD_W];
  endfunction

  function automatic logic in_route(input logic [31:0] a);
    in_route = (a[31:ROUTE_LSB] == ADDR_ROUTE[31:ROUTE_LSB]) && (a[1:0] == 2'h0);
  endfunction

  //==============================================================
  // declarations
  iir_route_if rt ();
  logic [NUM_SRC-1:0] src_lvl;
  logic [NUM_SRC-1:0] lvl_prev_ff;
  logic [NUM_SRC-1:0] pending_ff;
  logic [NUM_SRC-1:0] enable_ff;
  logic [NUM_SRC-1:0] mode_ff;
  logic [31:0] pol_ff;
  logic [NUM_SRC-1:0] rise;
  logic [NUM_SRC-1:0] clr_vec;
  logic [NUM_SRC-1:0] set_vec;
  logic [NUM_SRC-1:0] nxt_pending;
  logic [NUM_SRC-1:0] core_stat [NUM_CORE];
  logic [NUM_SRC-1:0] line_sel [NUM_LINE];
  logic [NUM_CORE*NUM_LINE-1:0] nxt_core_int;
  logic [NUM_CORE-1:0] core_any;
  logic [NUM_CORE-1:0] core_any_ff;
  logic [EVT_W-1:0] evt_ff;
  logic [EVT_W-1:0] evt_mask_ff;
  logic [EVT_W-1:0] evt_new;
  logic [EVT_W-1:0] evt_w1c;
  logic access;
  logic wr_fire;
  logic rd_capture;
  logic [31:0] nxt_prdata;
  logic nxt_err;
  logic [SRC_W-1:0] chk_idx;

  //==============================================================
  // sub-blocks
  iir_src_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw(src_in),
    .lvl_ff(src_lvl)
  );

  iir_route_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .rt(rt.mem)
  );

  //==============================================================
  // apb phases: one wait cycle, write lands on the pready edge
  assign access = psel && penable;
  assign rd_capture = access && !pready_ff;
  assign wr_fire = access && pready_ff && pwrite && !pslverr_ff;

  // table port driven from the live address
  assign rt.rd_word = word_idx(paddr);
  assign rt.wr_word = word_idx(paddr);
  assign rt.wr_strb = pstrb;
  assign rt.wr_data = pwdata;
  assign rt.wr_en = wr_fire && in_route(paddr); // see R1

  // read mux and address decode
  always_comb begin
    nxt_prdata = 32'h00000000;
    nxt_err = 1'b0;
    if (in_route(paddr)) begin
      nxt_prdata = rt.rd_data;
    end else begin
      case (paddr)
        ADDR_PEND: nxt_prdata = pending_ff; // see R2
        ADDR_EN: nxt_prdata = enable_ff; // see R3
        ADDR_SET, ADDR_CLR, ADDR_POL, ADDR_MODE: nxt_prdata = 32'h00000000;
        ADDR_CORE0: nxt_prdata = core_stat[0]; // see R7
        ADDR_CORE1: nxt_prdata = core_stat[1]; // see R7
        ADDR_CORE2: nxt_prdata = core_stat[2]; // see R7
        ADDR_CORE3: nxt_prdata = core_stat[3]; // see R7
        ADDR_EVT_STAT: nxt_prdata = 32'(evt_ff);
        ADDR_EVT_MASK: nxt_prdata = 32'(evt_mask_ff);
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= rd_capture;
      pslverr_ff <= rd_capture && nxt_err;
      if (rd_capture) begin
        prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
      end
    end
  end

  //==============================================================
  // enable state, only through set and clear ports
  assign set_vec = (wr_fire && paddr == ADDR_SET) ? pwdata : '0;
  assign clr_vec = (wr_fire && paddr == ADDR_CLR) ? pwdata : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= EN_RST;
    end else begin
      enable_ff <= (enable_ff | set_vec) & ~clr_vec; // see R3 R4 R5
    end
  end

  // trigger mode and the unused polarity word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= MODE_RST;
      pol_ff <= POL_RST;
    end else begin
      if (wr_fire && paddr == ADDR_MODE) begin
        mode_ff <= pwdata; // see R6
      end
      if (wr_fire && paddr == ADDR_POL) begin
        pol_ff <= pwdata;
      end
    end
  end

  //==============================================================
  // pending: pulse latches on a rising level, set beats a same-cycle clear
  assign rise = src_lvl & ~lvl_prev_ff;
  assign nxt_pending = (mode_ff & ((pending_ff & ~clr_vec) | rise)) // see R5 R8
                     | (~mode_ff & src_lvl); // see R6 R8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_prev_ff <= '0;
      pending_ff <= '0;
    end else begin
      lvl_prev_ff <= src_lvl;
      pending_ff <= nxt_pending;
    end
  end

  //==============================================================
  // per-core status and line fan-in from the routing entries
  always_comb begin
    for (int k = 0; k < NUM_CORE; k++) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        core_stat[k][i] = pending_ff[i] & enable_ff[i]
                        & rt.entries[i][ROUTE_CORE_LSB + k]; // see R1 R7
      end
    end
    for (int l = 0; l < NUM_LINE; l++) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        line_sel[l][i] = rt.entries[i][ROUTE_LINE_LSB + l]; // see R1
      end
    end
    for (int k = 0; k < NUM_CORE; k++) begin
      core_any[k] = |core_stat[k];
      for (int l = 0; l < NUM_LINE; l++) begin
        nxt_core_int[k*NUM_LINE + l] = |(core_stat[k] & line_sel[l]);
      end
    end
  end

  // routed lines to the cores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_int_ff <= '0;
      core_any_ff <= '0;
    end else begin
      core_int_ff <= nxt_core_int;
      core_any_ff <= core_any;
    end
  end

  //==============================================================
  // event status: core gains a routed interrupt, or an unmapped access
  always_comb begin
    evt_new = '0;
    evt_new[NUM_CORE-1:0] = core_any & ~core_any_ff;
    evt_new[EVT_ERR] = rd_capture && nxt_err;
  end
  assign evt_w1c = (wr_fire && paddr == ADDR_EVT_STAT) ? pwdata[EVT_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= EVT_RST;
      evt_mask_ff <= EVT_RST;
      irq_ff <= 1'b0;
    end else begin
      evt_ff <= (evt_ff & ~evt_w1c) | evt_new;
      if (wr_fire && paddr == ADDR_EVT_MASK) begin
        evt_mask_ff <= pwdata[EVT_W-1:0];
      end
      irq_ff <= |(evt_ff & evt_mask_ff);
    end
  end

  //==============================================================
  // checks
  assign chk_idx = {word_idx(paddr), 2'h0};

  route_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (rt.wr_en && pstrb[0]) |=> rt.entries[$past(chk_idx)] == 8'($past(pwdata)))
    else $error("route entry not written");

  pend_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (rd_capture && !pwrite && paddr == ADDR_PEND) |=> prdata_ff == $past(pending_ff))
    else $error("pending read mismatch");

  en_set_a: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (wr_fire && paddr == ADDR_SET) |=> enable_ff == ($past(enable_ff) | $past(pwdata)))
    else $error("set port wrong");

  en_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    (wr_fire && paddr == ADDR_CLR) |=> (enable_ff & $past(pwdata)) == '0)
    else $error("clear port left enable");

  mode_write_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    (wr_fire && paddr == ADDR_MODE) |=> mode_ff == $past(pwdata))
    else $error("mode not written");

  level_pend_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    ##1 ((pending_ff ^ $past(src_lvl)) & ~$past(mode_ff)) == '0)
    else $error("level pending wrong");

  pulse_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    ##1 ($past(pending_ff) & $past(mode_ff) & mode_ff & ~$past(clr_vec) & ~pending_ff) == '0)
    else $error("pulse pending lost");

  core_line_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    (|core_int_ff[NUM_LINE-1:0]) |-> core_any_ff[0])
    else $error("core line without status");

  irq_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(evt_ff & evt_mask_ff)) |=> irq_ff ##1 1'b1)
    else $error("irq not raised");

  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(access) |-> !pready_ff ##1 pready_ff)
    else $error("apb wait wrong");

  en_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (rd_capture && !pwrite && paddr == ADDR_EN) |=> prdata_ff == $past(enable_ff))
    else $error("enable read mismatch");

  en_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    !(wr_fire && (paddr == ADDR_SET || paddr == ADDR_CLR)) |=> enable_ff == $past(enable_ff))
    else $error("enable changed without port write");

  clr_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    (wr_fire && paddr == ADDR_CLR)
    |=> (enable_ff & ~$past(pwdata)) == ($past(enable_ff) & ~$past(pwdata)))
    else $error("clear port touched zero bits");

  pulse_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    (wr_fire && paddr == ADDR_CLR)
    |=> (pending_ff & $past(pwdata) & $past(mode_ff) & ~$past(rise)) == '0)
    else $error("pulse pending not cleared");

  core0_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    (rd_capture && !pwrite && paddr == ADDR_CORE0)
    |=> (prdata_ff & ~$past(pending_ff & enable_ff)) == '0)
    else $error("core zero status not pending and enabled");

  core3_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    (rd_capture && !pwrite && paddr == ADDR_CORE3)
    |=> (prdata_ff & ~$past(pending_ff & enable_ff)) == '0)
    else $error("core three status not pending and enabled");

  route_read_a: assert property (@(posedge pclk) disable iff (!presetn) // see R1
    (rd_capture && !pwrite && in_route(paddr)) |=> prdata_ff[7:0] == rt.entries[$past(chk_idx)])
    else $error("route entry read mismatch");

  err_resp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_capture && nxt_err) |=> (pready_ff && pslverr_ff))
    else $error("unmapped access not refused");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");

  wr_data_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_capture && pwrite) |=> prdata_ff == '0)
    else $error("read data not zero on write");

  err_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_capture && nxt_err) |=> evt_ff[EVT_ERR])
    else $error("error event not set");

  core_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(core_any & ~core_any_ff))
    |=> (evt_ff[NUM_CORE-1:0] & $past(core_any & ~core_any_ff)) == $past(core_any & ~core_any_ff))
    else $error("core event not set");

  evt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && paddr == ADDR_EVT_STAT)
    |=> (evt_ff & $past(pwdata[EVT_W-1:0]) & ~$past(evt_new)) == '0)
    else $error("event not cleared by write one");

  irq_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((evt_ff & evt_mask_ff) == '0) |=> !irq_ff)
    else $error("irq without unmasked event");

  pol_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && paddr == ADDR_POL) |=> pol_ff == $past(pwdata))
    else $error("polarity word not stored");

  core3_line_a: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    (|core_int_ff[NUM_CORE*NUM_LINE-1 -: NUM_LINE]) |-> core_any_ff[NUM_CORE-1])
    else $error("core three line without status");

  mode_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // see R6
    (rd_capture && !pwrite && paddr == ADDR_MODE) |=> prdata_ff == '0)
    else $error("mode word readable");
endmodule
`default_nettype wire

// ===== iir_pkg.sv
// constants and register map of the io interrupt router
//==============================================================
// Operation
// R1: one 8-bit routing entry per source picks the target core and its line.
// R2: read-only 32-bit word shows which sources are pending.
// R3: read-only 32-bit word shows enable state; changed only by set and clear ports.
// R4: writing ones to the set port enables those sources; zeros leave them.
// R5: writing ones to the clear port disables them and clears latched pulse pendings.
// R6: trigger mode bit per source, 1 pulse, 0 level; resets to zero.
// R7: four read-only words show pending enabled sources routed to each core.
// R8: pulse sources latch until cleared; level sources pend while input asserted.
`default_nettype none
package iir_pkg;
  //==============================================================
  // sizes
  localparam int NUM_SRC = 32;
  localparam int NUM_CORE = 4;
  localparam int NUM_LINE = 4;
  localparam int SRC_W = 5;
  localparam int WORD_W = 3;
  localparam int EVT_W = 5;
  localparam int EVT_ERR = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_BYTES = 4;
  //==============================================================
  // register byte addresses
  localparam logic [31:0] ADDR_ROUTE = 32'h3FF01400;
  localparam logic [31:0] ADDR_PEND = 32'h3FF01420;
  localparam logic [31:0] ADDR_EN = 32'h3FF01424;
  localparam logic [31:0] ADDR_SET = 32'h3FF01428;
  localparam logic [31:0] ADDR_CLR = 32'h3FF0142C;
  localparam logic [31:0] ADDR_POL = 32'h3FF01430;
  localparam logic [31:0] ADDR_MODE = 32'h3FF01434;
  localparam logic [31:0] ADDR_CORE0 = 32'h3FF01440;
  localparam logic [31:0] ADDR_CORE1 = 32'h3FF01448;
  localparam logic [31:0] ADDR_CORE2 = 32'h3FF01450;
  localparam logic [31:0] ADDR_CORE3 = 32'h3FF01458;
  localparam logic [31:0] ADDR_EVT_STAT = 32'h3FF014E0;
  localparam logic [31:0] ADDR_EVT_MASK = 32'h3FF014E4;
  // route table spans eight words; upper address bits compared from here
  localparam int ROUTE_LSB = 5;
  localparam int WORD_LSB = 2;
  //==============================================================
  // routing entry fields: one-hot core in low nibble, one-hot line in high nibble
  localparam int ROUTE_CORE_LSB = 0;
  localparam int ROUTE_LINE_LSB = 4;
  //==============================================================
  // reset values
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [31:0] MODE_RST = 32'h00000000;
  localparam logic [31:0] POL_RST = 32'h00000000;
  localparam logic [31:0] EN_RST = 32'h00000000;
  localparam logic [EVT_W-1:0] EVT_RST = 5'h00;
endpackage
`default_nettype wire

// ===== iir_route_if.sv
// interface between the router core and its routing table memory
`timescale 1ns/1ps
`default_nettype none
interface iir_route_if;
  import iir_pkg::*;
  logic wr_en;
  logic [WORD_W-1:0] wr_word;
  logic [3:0] wr_strb;
  logic [31:0] wr_data;
  logic [WORD_W-1:0] rd_word;
  logic [31:0] rd_data;
  logic [7:0] entries [NUM_SRC];
  modport ctl (output wr_en, wr_word, wr_strb, wr_data, rd_word, input rd_data, entries);
  modport mem (input wr_en, wr_word, wr_strb, wr_data, rd_word, output rd_data, entries);
endinterface
`default_nettype wire

// ===== iir_route_mem.sv
// routing table: 32 byte entries, word writes with byte strobes, registered read
`timescale 1ns/1ps
`default_nettype none
module iir_route_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // table access
  iir_route_if.mem rt
);
  import iir_pkg::*;

  //==============================================================
  // entry storage, four entries per word, strobe per byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        rt.entries[i] <= ROUTE_RST;
      end
    end else if (rt.wr_en) begin
      for (int b = 0; b < WORD_BYTES; b++) begin
        if (rt.wr_strb[b]) begin
          rt.entries[{rt.wr_word, 2'(b)}] <= rt.wr_data[BYTE_W*b +: BYTE_W]; // see R1
        end
      end
    end
  end

  //==============================================================
  // read word registered every cycle from the presented index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rt.rd_data <= 32'h00000000;
    end else begin
      for (int b = 0; b < WORD_BYTES; b++) begin
        rt.rd_data[BYTE_W*b +: BYTE_W] <= rt.entries[{rt.rd_word, 2'(b)}];
      end
    end
  end
endmodule
`default_nettype wire

// ===== iir_src_sync.sv
// three-stage synchroniser for the source pins, changes taken once stages agree
`timescale 1ns/1ps
`default_nettype none
module iir_src_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins and settled levels
  input wire logic [iir_pkg::NUM_SRC-1:0] raw,
  output logic [iir_pkg::NUM_SRC-1:0] lvl_ff
);
  import iir_pkg::*;

  logic [NUM_SRC-1:0] s1_ff;
  logic [NUM_SRC-1:0] s2_ff;
  logic [NUM_SRC-1:0] s3_ff;
  logic [NUM_SRC-1:0] agree;

  //==============================================================
  // stage chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit moves only when stages two and three match
  assign agree = ~(s2_ff ^ s3_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_ff <= '0;
    end else begin
      lvl_ff <= (agree & s3_ff) | (~agree & lvl_ff);
    end
  end
endmodule
`default_nettype wire

// ===== iir_core_model.sv
// model of the four cores that receive the routed interrupt lines
`timescale 1ns/1ps
`default_nettype none
module iir_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // routed lines and bench control
  input wire logic [15:0] core_int,
  input wire logic seen_clr,
  output logic [15:0] seen_ff
);
  //==========
  // each core remembers every line raised to it until the bench clears the record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_ff <= 16'h0000;
    end else if (seen_clr) begin
      seen_ff <= 16'h0000;
    end else begin
      seen_ff <= seen_ff | core_int;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking testbench of the io interrupt router
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iir_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, irq_ff, seen_clr;
  logic [31:0] paddr, pwdata, prdata_ff, a, b, m, w;
  logic [3:0] pstrb;
  logic [NUM_SRC-1:0] src_in;
  logic [15:0] core_int_ff, seen_ff;
  logic [7:0] rt [NUM_SRC];
  logic [33:0] exq [$];
  logic [33:0] me;
  string nmq [$];
  string mn;
  int miscompares = 0;
  int n_checks = 0;
  //==========
  // design and core model
  iir_router iir_router_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .src_in(src_in),
    .core_int_ff(core_int_ff), .irq_ff(irq_ff));
  iir_core_model iir_core_model_inst (.pclk(pclk), .presetn(presetn), .core_int(core_int_ff),
    .seen_clr(seen_clr), .seen_ff(seen_ff));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  //==========
  // helpers
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer; the expected answer is queued for the monitor
  task automatic apb(logic wr, logic [31:0] ad, logic [31:0] d, logic [3:0] st, logic er,
      string nm);
    exq.push_back({~wr, er, d});
    nmq.push_back(nm);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [31:0] ad, logic [31:0] d);
    apb(1'b1, ad, d, 4'hF, 1'b0, "write");
  endtask
  task automatic rd(logic [31:0] ad, logic [31:0] e, string nm);
    apb(1'b0, ad, e, 4'h0, 1'b0, nm);
  endtask
  // sources routed to core k by the expected table
  function automatic logic [31:0] routed(int k);
    for (int s = 0; s < NUM_SRC; s++) routed[s] = rt[s][k];
  endfunction
  function automatic logic [15:0] lines(logic [31:0] p);
    lines = 16'h0000;
    for (int s = 0; s < NUM_SRC; s++)
      for (int k = 0; k < 16; k++)
        if (p[s] && rt[s][k/4] && rt[s][4+k%4]) lines[k] = 1'b1;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //==========
  // monitor: each completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready_ff === 1'b1) begin
      me = exq.pop_front();
      mn = nmq.pop_front();
      chk({mn, " error"}, {31'h0, me[32]}, {31'h0, pslverr_ff});
      if (me[33]) chk(mn, me[31:0], prdata_ff);
    end
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end
  //==========
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, src_in, seen_clr, presetn} = '0;
    void'($urandom(32'h27A93CB0));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_PEND, 32'h0, "pending");
    rd(ADDR_EN, EN_RST, "enable");
    for (int i = 0; i < 8; i++) rd(ADDR_ROUTE + 4 * i, {4{ROUTE_RST}}, "route");
    rd(ADDR_MODE, MODE_RST, "mode");
    rd(ADDR_POL, POL_RST, "polarity");
    for (int k = 0; k < 4; k++) rd(ADDR_CORE0 + 8 * k, 32'h0, "routed");
    rd(ADDR_EVT_MASK, 32'h0, "event mask");
    // refused accesses raise event bit 4
    apb(1'b0, 32'h3FF01438, 32'h0, 4'h0, 1'b1, "unmapped");
    apb(1'b1, ADDR_PEND + 1, 32'hFFFFFFFF, 4'hF, 1'b1, "misaligned");
    wr(ADDR_EN, 32'hFFFFFFFF);
    rd(ADDR_EN, 32'h0, "enable read only");
    wr(ADDR_POL, $urandom);
    rd(ADDR_POL, 32'h0, "polarity write only");
    rd(ADDR_EVT_STAT, 32'h10, "event status");
    chk("irq masked", 32'h0, {31'h0, irq_ff});
    wr(ADDR_EVT_MASK, 32'h10);
    repeat (3) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq_ff});
    wr(ADDR_EVT_STAT, 32'h10);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq_ff});
    wr(ADDR_EVT_MASK, 32'h0);
    // route table, then a partial word under byte strobes
    for (int i = 0; i < 8; i++) begin
      w = $urandom;
      wr(ADDR_ROUTE + 4 * i, w);
      for (int j = 0; j < 4; j++) rt[4*i+j] = w[8*j+:8];
    end
    w = $urandom;
    apb(1'b1, ADDR_ROUTE + 12, w, 4'h5, 1'b0, "strobe write");
    rt[12] = w[7:0];
    rt[14] = w[23:16];
    for (int i = 0; i < 8; i++)
      rd(ADDR_ROUTE + 4 * i, {rt[4*i+3], rt[4*i+2], rt[4*i+1], rt[4*i]}, "route");
    // enable set and clear ports
    a = $urandom;
    b = $urandom;
    m = $urandom;
    wr(ADDR_SET, a);
    rd(ADDR_EN, a, "enable set");
    wr(ADDR_SET, b);
    rd(ADDR_EN, a | b, "enable set again");
    wr(ADDR_CLR, m);
    rd(ADDR_EN, (a | b) & ~m, "enable clear");
    // level sources and routing to the cores
    wr(ADDR_CLR, 32'hFFFFFFFF);
    a = $urandom;
    src_in <= a;
    repeat (12) @(posedge pclk);
    rd(ADDR_PEND, a, "level pending");
    rd(ADDR_CORE0, 32'h0, "routed disabled");
    seen_clr <= 1'b1;
    @(posedge pclk);
    seen_clr <= 1'b0;
    wr(ADDR_SET, 32'hFFFFFFFF);
    for (int k = 0; k < 4; k++) rd(ADDR_CORE0 + 8 * k, routed(k) & a, "routed");
    // each core that gained a routed source has its event bit set
    w = 32'h0;
    for (int k = 0; k < 4; k++) w[k] = |(routed(k) & a);
    rd(ADDR_EVT_STAT, w, "core events");
    wr(ADDR_EVT_STAT, 32'hF);
    rd(ADDR_EVT_STAT, 32'h0, "core events cleared");
    repeat (3) @(posedge pclk);
    chk("core lines", {16'h0, lines(a)}, {16'h0, seen_ff});
    src_in <= '0;
    repeat (12) @(posedge pclk);
    rd(ADDR_PEND, 32'h0, "level released");
    // pulse sources latch until the clear port
    m = $urandom;
    wr(ADDR_MODE, m);
    rd(ADDR_MODE, 32'h0, "mode write only");
    b = $urandom;
    src_in <= b;
    repeat (3) @(posedge pclk);
    src_in <= '0;
    repeat (12) @(posedge pclk);
    rd(ADDR_PEND, b & m, "pulse pending");
    a = $urandom;
    wr(ADDR_CLR, a);
    rd(ADDR_PEND, b & m & ~a, "pulse cleared");
    rd(ADDR_EN, ~a, "enable after clear");
    conclude();
  end
endmodule
`default_nettype wire
